/* verilog/tvd_pkg.sv */
/*
 * Package for the trap and vector dispatch block: register map, trap flag
 * layout, fixed trap numbers, reset values and state encodings.
 * Assumes a 32-bit APB register bus and a 24-bit vector address space.
 */
package tvd_pkg;
	// Register byte offsets
	localparam logic [11:0] TVD_OFS_FLAGS = 12'h000;
	localparam logic [11:0] TVD_OFS_VSEG = 12'h004;
	localparam logic [11:0] TVD_OFS_CPU_CTRL = 12'h008;
	localparam logic [11:0] TVD_OFS_STATUS = 12'h00C;
	localparam logic [11:0] TVD_OFS_VADDR = 12'h010;

	// Trap flag bit positions
	localparam int TVD_B_SYSREQ0 = 15;
	localparam int TVD_B_STK_OVER = 14;
	localparam int TVD_B_STK_UNDER = 13;
	localparam int TVD_B_SWBRK = 12;
	localparam int TVD_B_SYSREQ1 = 7;
	localparam int TVD_B_UNDOP = 3;
	localparam int TVD_B_MEMERR = 2;
	localparam int TVD_B_PROT_FAULT = 1;
	localparam int TVD_B_ILL_OPERAND = 0;
	localparam logic [15:0] TVD_CLASS_A_MASK = 16'hF000;
	localparam logic [15:0] TVD_CLASS_B_MASK = 16'h008F;

	// Fixed trap numbers of the hardware traps and of the interrupt nodes
	localparam logic [6:0] TVD_TN_SYSREQ0 = 7'h02;
	localparam logic [6:0] TVD_TN_STK_OVER = 7'h04;
	localparam logic [6:0] TVD_TN_STK_UNDER = 7'h06;
	localparam logic [6:0] TVD_TN_SWBRK = 7'h08;
	localparam logic [6:0] TVD_TN_CLASS_B = 7'h0A;
	localparam logic [6:0] TVD_TN_SER2_REQ0 = 7'h5F;
	localparam logic [6:0] TVD_TN_UNASSIGNED_LO = 7'h62;
	localparam logic [6:0] TVD_TN_UNASSIGNED_HI = 7'h6A;
	localparam logic [6:0] TVD_TN_SYSCTL1 = 7'h6B;

	// Reset values
	localparam logic [7:0] TVD_VSEG_RST = 8'h00;
	localparam logic [1:0] TVD_VSC_RST = 2'h0;
	localparam int TVD_VSC_POS = 0;

	// Sources: trap = hardware, swtrap = TRAP instruction, irq = node
	typedef enum logic [1:0] {
		TVD_SRC_HW = 2'b00,
		TVD_SRC_SW = 2'b01,
		TVD_SRC_IRQ = 2'b10,
		TVD_SRC_NONE = 2'b11
	} tvd_src_t;

	typedef enum logic [1:0] {
		TVD_ST_RUN = 2'b00,
		TVD_ST_HWSVC = 2'b01,
		TVD_ST_WAIT = 2'b10
	} tvd_state_t;
endpackage

/* verilog/tvd_vec_calc.sv */
/*
 * Vector address arithmetic: segment base plus trap number times spacing.
 * Assumes pure combinational use by the dispatch block on the same clock.
 */
`timescale 1ns/100ps
module tvd_vec_calc
	import tvd_pkg::*;
(
	// Inputs
	input wire logic [7:0] vseg,
	input wire logic [1:0] vsc,
	input wire logic [6:0] trap_num,
	// Result
	output logic [23:0] vec_addr
);
	logic [15:0] offset;

	always_comb begin
		offset = {7'h00, trap_num, 2'b00} << vsc;
		vec_addr = {vseg, offset};
	end
endmodule // tvd_vec_calc

/* verilog/tvd_dispatch.sv */
/*
 * Trap and vector dispatch: collects hardware trap events into sticky flags,
 * forces a non-maskable branch to the trap vector, dispatches software traps
 * and interrupt node requests, and holds the vector segment and spacing.
 * Assumes the sequencer acknowledges each branch with branch_ack and signals
 * the end of a hardware trap service with hw_svc_done; all inputs are on pclk.
 */
// Behaviour
// - Any hardware trap forces a non-maskable branch: class A to its own vector, class B to the shared one.
// - Each hardware trap sets its own bit in the trap flag register.
// - Hardware trap preempts execution; during trap service only a class A trap preempts, and only class B service.
// - During hardware trap service, interrupts and event transfers are held off.
// - Class A traps use vectors 0x08, 0x10, 0x18, 0x20, numbers 02-08.
// - All five class B traps share vector 0x28, number 0A.
// - Software trap reaches any number 00-7F at current CPU priority.
// - Vector table sits in the segment held in the vector segment register.
// - Vector spacing comes from the spacing field; default four bytes.
// - Serial channel two sub-channel one requests use numbers 5F, 60, 61.
// - Numbers 62-6A unassigned; 6B-6F serve system, flash, clock, transfer-end.
`timescale 1ns/100ps
module tvd_dispatch
	import tvd_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trap events, one-cycle pulses, bit layout as the flag register
	input wire logic [15:0] trap_event,
	// Software trap instruction
	input wire logic sw_trap_req,
	input wire logic [6:0] sw_trap_num,
	// Interrupt node request, already arbitrated
	input wire logic irq_req,
	input wire logic [6:0] irq_num,
	input wire logic pet_req,
	// Sequencer handshake
	input wire logic branch_ack,
	input wire logic hw_svc_done,
	// Sequencer outputs
	output logic branch_req,
	output logic [23:0] branch_addr,
	output logic [6:0] branch_num,
	output logic branch_nmi,
	output logic irq_block,
	output logic pet_grant
);
	typedef struct packed {
		logic [15:0] flags;
		logic [7:0] vseg;
		logic [1:0] vsc;
		tvd_state_t state;
		logic class_a_svc;
		logic [15:0] pend;
		logic branch_req;
		logic [23:0] branch_addr;
		logic [6:0] branch_num;
		logic branch_nmi;
		logic irq_block;
		logic pet_grant;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tvd_regs_t;

	tvd_regs_t r, next_r;
	logic [6:0] pick_num;
	logic pick_valid;
	logic pick_hw;
	logic pick_class_a;
	logic [23:0] pick_addr;

	function automatic logic [6:0] hw_trap_num(input logic [15:0] f);
		if (f[TVD_B_SYSREQ0]) return TVD_TN_SYSREQ0;
		if (f[TVD_B_STK_OVER]) return TVD_TN_STK_OVER;
		if (f[TVD_B_STK_UNDER]) return TVD_TN_STK_UNDER;
		if (f[TVD_B_SWBRK]) return TVD_TN_SWBRK;
		return TVD_TN_CLASS_B;
	endfunction

	// Only the class A trap being served leaves the pending set; a second one
	// raised in the same cycle waits its turn instead of being dropped
	function automatic logic [15:0] hw_trap_bit(input logic [15:0] f);
		logic [15:0] b;
		b = 16'h0000;
		if (f[TVD_B_SYSREQ0])
			b[TVD_B_SYSREQ0] = 1'b1;
		else if (f[TVD_B_STK_OVER])
			b[TVD_B_STK_OVER] = 1'b1;
		else if (f[TVD_B_STK_UNDER])
			b[TVD_B_STK_UNDER] = 1'b1;
		else if (f[TVD_B_SWBRK])
			b[TVD_B_SWBRK] = 1'b1;
		return b;
	endfunction

	function automatic logic node_assigned(input logic [6:0] n);
		return !(n >= TVD_TN_UNASSIGNED_LO && n <= TVD_TN_UNASSIGNED_HI);
	endfunction

	tvd_vec_calc u_vec (
		.vseg(r.vseg),
		.vsc(r.vsc),
		.trap_num(pick_num),
		.vec_addr(pick_addr)
	);

	logic [15:0] new_hw;
	logic wr_acc, rd_acc, addr_ok;

	always_comb begin
		new_hw = r.pend | trap_event;
		pick_valid = 1'b0;
		pick_hw = 1'b0;
		pick_class_a = 1'b0;
		pick_num = 7'h00;
		// hardware trap wins, class B waits while class A service runs
		if (r.state == TVD_ST_RUN && (|(new_hw & TVD_CLASS_A_MASK)
				|| (|(new_hw & TVD_CLASS_B_MASK)))) begin
			pick_valid = 1'b1;
			pick_hw = 1'b1;
			pick_class_a = |(new_hw & TVD_CLASS_A_MASK);
			pick_num = hw_trap_num(new_hw);
		end else if (r.state == TVD_ST_HWSVC && !r.class_a_svc && |(new_hw & TVD_CLASS_A_MASK)) begin
			pick_valid = 1'b1;
			pick_hw = 1'b1;
			pick_class_a = 1'b1;
			pick_num = hw_trap_num(new_hw);
		end else if (r.state == TVD_ST_RUN && sw_trap_req) begin
			pick_valid = 1'b1;
			pick_num = sw_trap_num;
		end else if (r.state == TVD_ST_RUN && irq_req && node_assigned(irq_num)) begin
			pick_valid = 1'b1;
			pick_num = irq_num;
		end
	end

	always_comb begin
		next_r = r;
		wr_acc = psel && penable && pwrite;
		rd_acc = psel && !penable && !pwrite;
		addr_ok = paddr == TVD_OFS_FLAGS || paddr == TVD_OFS_VSEG || paddr == TVD_OFS_CPU_CTRL
			|| paddr == TVD_OFS_STATUS || paddr == TVD_OFS_VADDR;
		next_r.pready = psel && !penable;
		next_r.pslverr = psel && !penable && !addr_ok;
		next_r.pend = new_hw;
		// clear by write of ones, set wins
		if (wr_acc && paddr == TVD_OFS_FLAGS)
			next_r.flags = r.flags & ~pwdata[15:0];
		next_r.flags = next_r.flags | trap_event;
		if (wr_acc && paddr == TVD_OFS_VSEG)
			next_r.vseg = pwdata[7:0];
		if (wr_acc && paddr == TVD_OFS_CPU_CTRL)
			next_r.vsc = pwdata[TVD_VSC_POS +: 2];
		if (rd_acc) begin
			case (paddr)
				TVD_OFS_FLAGS: next_r.prdata = {16'h0000, r.flags};
				TVD_OFS_VSEG: next_r.prdata = {24'h000000, r.vseg};
				TVD_OFS_CPU_CTRL: next_r.prdata = {30'h00000000, r.vsc};
				// Pending flag covers all four class A traps, not just the top two
				TVD_OFS_STATUS: next_r.prdata = {28'h0000000, |(r.pend & TVD_CLASS_A_MASK), r.class_a_svc, r.state};
				TVD_OFS_VADDR: next_r.prdata = {8'h00, r.branch_addr};
				default: next_r.prdata = 32'h00000000;
			endcase
		end
		case (r.state)
			TVD_ST_RUN, TVD_ST_HWSVC: begin
				if (pick_valid) begin
					next_r.branch_req = 1'b1;
					next_r.branch_addr = pick_addr;
					next_r.branch_num = pick_num;
					next_r.branch_nmi = pick_hw;
					if (pick_hw) begin
						next_r.pend = pick_class_a ? (new_hw & ~hw_trap_bit(new_hw)) : 16'h0000;
						next_r.class_a_svc = pick_class_a;
					end
					next_r.state = TVD_ST_WAIT;
				end else if (r.state == TVD_ST_HWSVC && hw_svc_done) begin
					next_r.state = TVD_ST_RUN;
					next_r.class_a_svc = 1'b0;
				end
			end
			TVD_ST_WAIT: begin
				if (branch_ack) begin
					next_r.branch_req = 1'b0;
					next_r.state = r.branch_nmi ? TVD_ST_HWSVC : TVD_ST_RUN;
				end
			end
			default: next_r.state = TVD_ST_RUN;
		endcase
		// block interrupts and event transfers in hardware service
		next_r.irq_block = next_r.state != TVD_ST_RUN || next_r.branch_nmi && next_r.branch_req;
		next_r.pet_grant = pet_req && !next_r.irq_block;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.vseg <= TVD_VSEG_RST;
			r.vsc <= TVD_VSC_RST;
			r.state <= TVD_ST_RUN;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign branch_req = r.branch_req;
	assign branch_addr = r.branch_addr;
	assign branch_num = r.branch_num;
	assign branch_nmi = r.branch_nmi;
	assign irq_block = r.irq_block;
	assign pet_grant = r.pet_grant;

	sequence s_hw_event;
		(r.state == TVD_ST_RUN) && (|trap_event);
	endsequence

	sequence s_branch_start;
		$rose(branch_req);
	endsequence

	chk_hw_branch_issued: assert property (@(posedge pclk) disable iff (!presetn)
		s_hw_event |=> branch_req && branch_nmi)
		else $error("hardware trap did not raise a branch");
	chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
		(|trap_event) |=> ((r.flags & $past(trap_event)) == $past(trap_event)))
		else $error("trap flag not set");
	chk_no_preempt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(r.state == TVD_ST_HWSVC && r.class_a_svc) |=> !(branch_req && !$past(branch_req)))
		else $error("class A service preempted");
	chk_irq_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		(r.state == TVD_ST_HWSVC) |-> irq_block && !pet_grant)
		else $error("interrupts not blocked in trap service");
	chk_class_b_num: assert property (@(posedge pclk) disable iff (!presetn)
		(s_hw_event and (trap_event & TVD_CLASS_A_MASK) == 16'h0000 && r.pend == 16'h0000)
		|=> branch_num == TVD_TN_CLASS_B)
		else $error("class B trap number wrong");
	chk_unassigned: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(branch_req) && !branch_nmi && !$past(sw_trap_req) |-> node_assigned(branch_num))
		else $error("unassigned node dispatched");
	chk_vec_addr: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(branch_req) |-> branch_addr == {r.vseg, 16'({7'h00, branch_num, 2'b00} << r.vsc)})
		else $error("vector address wrong");
	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && penable && pwrite && paddr == TVD_OFS_FLAGS) |=> ((r.flags & $past(r.flags)) == $past(r.flags)))
		else $error("trap flag lost without write");
	chk_sw_num: assert property (@(posedge pclk) disable iff (!presetn)
		(r.state == TVD_ST_RUN && sw_trap_req && trap_event == 16'h0000 && r.pend == 16'h0000)
		|=> branch_num == $past(sw_trap_num) && !branch_nmi)
		else $error("software trap number wrong");
	chk_class_a_num: assert property (@(posedge pclk) disable iff (!presetn)
		(s_hw_event and trap_event[TVD_B_SYSREQ0]) |=> branch_num == TVD_TN_SYSREQ0 && branch_nmi)
		else $error("class A trap number wrong");
	chk_seg_base: assert property (@(posedge pclk) disable iff (!presetn)
		s_branch_start |-> branch_addr[23:16] == r.vseg)
		else $error("vector segment missing from address");
	chk_block_release: assert property (@(posedge pclk) disable iff (!presetn)
		(r.state == TVD_ST_HWSVC && r.class_a_svc && hw_svc_done) |=> !irq_block)
		else $error("interrupt block held after service end");
	chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && paddr == TVD_OFS_FLAGS && trap_event == 16'h0000)
		|=> r.flags == ($past(r.flags) & ~$past(pwdata[15:0])))
		else $error("trap flag clear wrong");
	chk_class_b_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(r.state == TVD_ST_HWSVC && !r.class_a_svc && (new_hw & TVD_CLASS_A_MASK) == 16'h0000) |=> !branch_req)
		else $error("class B service preempted");
	chk_sw_dispatch: assert property (@(posedge pclk) disable iff (!presetn)
		(r.state == TVD_ST_RUN && sw_trap_req && new_hw == 16'h0000) |=> branch_req && !branch_nmi)
		else $error("software trap not dispatched");
endmodule // tvd_dispatch

/* bench/tvd_seq_model.sv */
/*
 * Sequencer stand-in: acknowledges branch requests after a set delay and
 * ends each hardware trap service a set number of cycles after its branch.
 * Assumes the dispatch block's branch handshake, all on pclk.
 */
`timescale 1ns/100ps
module tvd_seq_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Dispatch side
	input wire logic branch_req,
	input wire logic branch_nmi,
	output logic branch_ack,
	output logic hw_svc_done,
	// Pacing set by the bench
	input wire logic [3:0] ack_delay,
	input wire logic [7:0] svc_len
);
	logic [3:0] wait_cnt;
	logic [7:0] svc_cnt;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branch_ack <= 1'b0;
			hw_svc_done <= 1'b0;
			wait_cnt <= '0;
			svc_cnt <= '0;
		end else begin
			branch_ack <= 1'b0;
			hw_svc_done <= 1'b0;
			// One acknowledge per request, never while the last one is still seen
			if (branch_req && !branch_ack) begin
				if (wait_cnt >= ack_delay) begin
					branch_ack <= 1'b1;
					wait_cnt <= '0;
					if (branch_nmi)
						svc_cnt <= svc_len;
				end else
					wait_cnt <= wait_cnt + 4'h1;
			end else if (svc_cnt == 8'h01) begin
				hw_svc_done <= 1'b1;
				svc_cnt <= '0;
			end else if (svc_cnt > 8'h01)
				svc_cnt <= svc_cnt - 8'h01;
		end
	end
endmodule // tvd_seq_model

/* bench/test_trap_and_vector_dispatch.sv */
/*
 * Testbench for the trap and vector dispatch block: APB register tasks,
 * trap, software trap and node requests, service blocking checks.
 * Assumes tvd_pkg and the sequencer model are compiled first.
 */
`timescale 1ns/100ps
module test_trap_and_vector_dispatch;
	import tvd_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic sw_trap_req, irq_req, pet_req, branch_ack, hw_svc_done;
	logic branch_req, branch_nmi, irq_block, pet_grant;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] trap_event;
	logic [6:0] sw_trap_num, irq_num, branch_num;
	logic [23:0] branch_addr;
	logic [3:0] ack_delay;
	logic [7:0] svc_len, vseg_v;
	logic [1:0] code_v;
	int mismatches, checks, cyc;
	logic [15:0] tbits [9] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0080, 16'h0008, 16'h0004,
		16'h0002, 16'h0001};
	logic [6:0] tnums [9] = '{7'h02, 7'h04, 7'h06, 7'h08, 7'h0A, 7'h0A, 7'h0A, 7'h0A, 7'h0A};
	logic [6:0] inums [8] = '{7'h5F, 7'h60, 7'h61, 7'h6B, 7'h6F, 7'h00, 7'h7F, 7'h65};

	tvd_dispatch i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trap_event(trap_event), .sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num), .irq_req(irq_req),
		.irq_num(irq_num), .pet_req(pet_req), .branch_ack(branch_ack), .hw_svc_done(hw_svc_done),
		.branch_req(branch_req), .branch_addr(branch_addr), .branch_num(branch_num),
		.branch_nmi(branch_nmi), .irq_block(irq_block), .pet_grant(pet_grant));
	tvd_seq_model i_seq (.pclk(pclk), .presetn(presetn), .branch_req(branch_req), .branch_nmi(branch_nmi),
		.branch_ack(branch_ack), .hw_svc_done(hw_svc_done), .ack_delay(ack_delay), .svc_len(svc_len));

	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	// Whole run is a few hundred cycles; the ceiling only catches a hang
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end

	task final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Requests drop once taken so a held level is not dispatched twice
	task seen_branch(input logic [6:0] n, input logic nmi);
		do @(posedge pclk); while (branch_req !== 1'b1);
		irq_req <= 1'b0;
		sw_trap_req <= 1'b0;
		chk(32'(branch_num), 32'(n));
		chk(32'(branch_nmi), 32'(nmi));
		chk(32'(branch_addr), 32'({vseg_v, 16'((16'(n) << 2) << code_v)}));
		do @(posedge pclk); while (branch_req === 1'b1);
	endtask

	task trap(input logic [15:0] bits);
		@(posedge pclk);
		trap_event <= bits;
		@(posedge pclk);
		trap_event <= '0;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, sw_trap_req, irq_req, pet_req} = '0;
		{paddr, pwdata, trap_event, sw_trap_num, irq_num} = '0;
		{ack_delay, vseg_v, code_v, cyc, mismatches, checks} = '0;
		svc_len = 8'h03;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h014, 32'hFFFFFFFF);
		chk(32'(err), 32'h1);
		apb(1'b0, TVD_OFS_VSEG, '0);
		chk(rd, 32'(TVD_VSEG_RST));
		apb(1'b0, TVD_OFS_CPU_CTRL, '0);
		chk(rd, 32'(TVD_VSC_RST));
		for (int i = 0; i < 9; i++) begin
			ack_delay <= 4'(i);
			trap(tbits[i]);
			seen_branch(tnums[i], 1'b1);
			do @(posedge pclk); while (irq_block === 1'b1);
		end
		apb(1'b0, TVD_OFS_FLAGS, '0);
		chk(32'(rd[15:0]), 32'h0000F08F);
		apb(1'b1, TVD_OFS_FLAGS, 32'h00008000);
		apb(1'b0, TVD_OFS_FLAGS, '0);
		chk(32'(rd[15:0]), 32'h0000708F);
		apb(1'b1, TVD_OFS_FLAGS, 32'h0000FFFF);
		apb(1'b0, TVD_OFS_FLAGS, '0);
		chk(32'(rd[15:0]), 32'h0);
		vseg_v = 8'h12;
		code_v = 2'h1;
		ack_delay <= 4'h0;
		apb(1'b1, TVD_OFS_VSEG, 32'h12);
		apb(1'b1, TVD_OFS_CPU_CTRL, 32'h1);
		apb(1'b0, TVD_OFS_CPU_CTRL, '0);
		chk(rd, 32'h1);
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			if (i < 5) begin
				irq_req <= 1'b1;
				irq_num <= inums[i];
			end else begin
				sw_trap_req <= 1'b1;
				sw_trap_num <= inums[i];
			end
			seen_branch(inums[i], 1'b0);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge pclk);
			irq_req <= 1'b1;
			irq_num <= k ? TVD_TN_UNASSIGNED_HI : TVD_TN_UNASSIGNED_LO;
			repeat (8) begin
				@(posedge pclk);
				chk(32'(branch_req), 32'h0);
			end
			irq_req <= 1'b0;
		end
		svc_len <= 8'd20;
		trap(16'h0001);
		seen_branch(TVD_TN_CLASS_B, 1'b1);
		irq_req <= 1'b1;
		irq_num <= TVD_TN_SER2_REQ0;
		pet_req <= 1'b1;
		repeat (5) begin
			@(posedge pclk);
			chk(32'(irq_block), 32'h1);
			chk(32'(pet_grant), 32'h0);
			chk(32'(branch_req), 32'h0);
		end
		apb(1'b0, TVD_OFS_STATUS, '0);
		chk(rd, 32'h00000001);
		apb(1'b0, TVD_OFS_VADDR, '0);
		chk(rd, 32'h00120050);
		do @(posedge pclk); while (irq_block === 1'b1);
		seen_branch(TVD_TN_SER2_REQ0, 1'b0);
		chk(32'(pet_grant), 32'h1);
		pet_req <= 1'b0;
		// Class A cuts into class B service; two class A traps at once are both served
		trap(16'h0080);
		seen_branch(TVD_TN_CLASS_B, 1'b1);
		trap(16'h6000);
		seen_branch(TVD_TN_STK_OVER, 1'b1);
		apb(1'b0, TVD_OFS_STATUS, '0);
		chk(rd, 32'h0000000D);
		do @(posedge pclk); while (irq_block === 1'b1);
		seen_branch(TVD_TN_STK_UNDER, 1'b1);
		do @(posedge pclk); while (irq_block === 1'b1);
		final_report();
	end
endmodule // test_trap_and_vector_dispatch
